// >>> src/ufp_port.sv
// Byte-wide parallel FIFO port with Wishbone control registers
module ufp_port
    import ufp_pkg::*;
#(
    parameter int TXD = TX_DEPTH,
    parameter int RXD = RX_DEPTH,
    parameter int MSC = MS_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // FIFO pins
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic [7:0] data_oe_o,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic tx_space_avail_n_o,
    output logic rx_data_avail_n_o,
    input wire logic send_now_wake_n_i,
    output logic power_enable_n_o,
    output logic fifo_pulldown_o,
    input wire logic reset_in_n_i,
    output logic reset_out_n_o,
    // USB engine side
    input wire logic usb_suspend_i,
    input wire logic usb_rx_valid_i,
    input wire logic [7:0] usb_rx_data_i,
    output logic usb_rx_ready_o,
    input wire logic usb_in_pop_i,
    output logic [7:0] usb_in_data_o,
    output logic usb_in_avail_o,
    output logic usb_send_now_o,
    output logic usb_flush_o,
    output logic usb_resume_o,
    output logic usb_iso_mode_o,
    input wire logic usb_tmo_we_i,
    input wire logic [7:0] usb_tmo_i
);
    localparam int TXW = $clog2(TXD);
    localparam int RXW = $clog2(RXD);
    localparam logic [TXW:0] TX_FULL = (TXW + 1)'(TXD);
    localparam logic [RXW:0] RX_FULL = (RXW + 1)'(RXD);
    localparam logic [TXW-1:0] TX_LAST = TXW'(TXD - 1);
    localparam logic [RXW-1:0] RX_LAST = RXW'(RXD - 1);
    localparam logic [15:0] MS_LAST = 16'(MSC - 1);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [TXD-1:0][7:0] txm;
        logic [TXW-1:0] twp;
        logic [TXW-1:0] trp;
        logic [TXW:0] tcn;
        logic [RXD-1:0][7:0] rxm;
        logic [RXW-1:0] rwp;
        logic [RXW-1:0] rrp;
        logic [RXW:0] rcn;
        logic [1:0] rds;
        logic [1:0] wrs;
        logic [1:0] sis;
        logic [1:0] rss;
        logic [1:0][7:0] dts;
        logic rdp;
        logic wrp;
        logic sip;
        logic tbusy;
        logic rhold;
        logic [7:0] dout;
        logic doe;
        logic [NCTL-1:0] ctrl;
        logic [7:0] tmo;
        logic [7:0] bbo;
        logic [7:0] bbd;
        logic [NEV-1:0] sts;
        logic [NEV-1:0] msk;
        logic ack;
        logic [31:0] rdat;
        logic [15:0] msc;
        logic [7:0] tmc;
        logic flush;
        logic snow;
        logic wake;
        logic susp;
        logic rsto;
    } ufp_st_t;

    ufp_st_t q;
    ufp_st_t d;
    logic bb;
    logic run;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    logic si_fall;
    logic rd_ok;
    logic wr_ok;
    logic push;
    logic pop;
    logic wb_go;
    logic [NEV-1:0] ev;

    // ****************************************
    // Strobe edges from synchronised pins
    // ****************************************
    assign bb = q.ctrl[C_BB];
    assign run = q.rss[1] && !bb;
    assign rd_fall = q.rdp && !q.rds[1];
    assign rd_rise = !q.rdp && q.rds[1];
    assign wr_fall = q.wrp && !q.wrs[1];
    assign wr_rise = !q.wrp && q.wrs[1];
    assign si_fall = q.sip && !q.sis[1];
    assign rd_ok = rd_fall && run && !q.rhold && q.rcn != '0;
    assign wr_ok = wr_fall && run && !q.tbusy && q.tcn != TX_FULL;
    assign push = usb_rx_valid_i && q.rss[1] && q.rcn != RX_FULL;
    // Drained at the engine's pace only, no baud divider exists
    assign pop = usb_in_pop_i && q.tcn != '0;
    assign wb_go = wb_cyc_i && wb_stb_i && !q.ack;

    // Events that set sticky status
    always_comb begin
        ev = '0;
        ev[E_RX] = push;
        ev[E_OVF] = usb_rx_valid_i && q.rcn == RX_FULL;
        ev[E_FLUSH] = d.flush;
        ev[E_WAKE] = d.wake;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.flush = 1'b0;
        d.wake = 1'b0;
        d.ack = wb_go;
        // Two flops on every pin before use
        d.rds = {q.rds[0], rd_n_i};
        d.wrs = {q.wrs[0], wr_n_i};
        d.sis = {q.sis[0], send_now_wake_n_i};
        d.rss = {q.rss[0], reset_in_n_i};
        d.dts = {q.dts[0], data_i};
        d.rdp = q.rds[1];
        d.wrp = q.wrs[1];
        d.sip = q.sis[1];
        d.susp = usb_suspend_i;
        d.rsto = q.rss[1];
        // Host bytes into receive buffer
        if (push) begin
            d.rxm[q.rwp] = usb_rx_data_i;
            d.rwp = (q.rwp == RX_LAST) ? '0 : q.rwp + 1'b1;
        end
        // Read strobe hands out one byte and holds the flag off
        if (rd_ok) begin
            d.dout = q.rxm[q.rrp];
            d.doe = 1'b1;
            d.rhold = 1'b1;
            d.rrp = (q.rrp == RX_LAST) ? '0 : q.rrp + 1'b1;
        end
        if (rd_rise) begin
            d.doe = 1'b0;
            d.rhold = 1'b0;
        end
        d.rcn = q.rcn + (RXW + 1)'(push) - (RXW + 1)'(rd_ok);
        // Write strobe stores the pin byte, flag high until strobe ends
        if (wr_ok) begin
            d.txm[q.twp] = q.dts[1];
            d.twp = (q.twp == TX_LAST) ? '0 : q.twp + 1'b1;
            d.tbusy = 1'b1;
        end
        if (wr_rise) begin
            d.tbusy = 1'b0;
        end
        if (pop) begin
            d.trp = (q.trp == TX_LAST) ? '0 : q.trp + 1'b1;
            d.snow = 1'b0;
        end
        d.tcn = q.tcn + (TXW + 1)'(wr_ok) - (TXW + 1)'(pop);
        // Send-now strobe: resume request in suspend if wakeup allowed, early send when not suspended
        if (si_fall && q.rss[1]) begin
            if (q.susp && q.ctrl[C_WAKE]) begin
                d.wake = 1'b1;
            end else if (!q.susp) begin
                d.snow = 1'b1;
            end
        end
        // Flush timer restarts on each write, runs while data waits
        if (q.tcn == '0 || wr_ok) begin
            d.msc = '0;
            d.tmc = '0;
        end else if (q.msc == MS_LAST) begin
            d.msc = '0;
            d.tmc = q.tmc + 1'b1;
            if (q.tmc + 1'b1 >= q.tmo) begin
                d.flush = 1'b1;
                d.tmc = '0;
            end
        end else begin
            d.msc = q.msc + 1'b1;
        end
        // Timeout set over USB, zero is raised to the least step
        if (usb_tmo_we_i) begin
            d.tmo = (usb_tmo_i < TMO_MIN) ? TMO_MIN : usb_tmo_i;
        end
        // External reset empties both buffers
        if (!q.rss[1]) begin
            d.twp = '0;
            d.trp = '0;
            d.tcn = '0;
            d.rwp = '0;
            d.rrp = '0;
            d.rcn = '0;
            d.tbusy = 1'b0;
            d.rhold = 1'b0;
            d.doe = 1'b0;
            d.snow = 1'b0;
        end
        // Register writes
        if (wb_go && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                A_CTRL: d.ctrl = wb_dat_i[NCTL-1:0];
                A_BBO: d.bbo = wb_dat_i[7:0];
                A_BBD: d.bbd = wb_dat_i[7:0];
                A_MASK: d.msk = wb_dat_i[NEV-1:0];
                default: ;
            endcase
        end
        // Register reads; a status read clears, a new event still wins
        d.rdat = '0;
        if (wb_go && !wb_we_i) begin
            unique case (wb_adr_i)
                A_CTRL: d.rdat[NCTL-1:0] = q.ctrl;
                A_TMO: d.rdat[7:0] = q.tmo;
                A_BBO: d.rdat[7:0] = q.bbo;
                A_BBD: d.rdat[7:0] = q.bbd;
                A_STAT: d.rdat[NEV-1:0] = q.sts;
                A_MASK: d.rdat[NEV-1:0] = q.msk;
                A_LVL: begin
                    d.rdat[L_RXC +: RXW + 1] = q.rcn;
                    d.rdat[L_TXC +: TXW + 1] = q.tcn;
                    d.rdat[L_PIN +: 8] = q.dts[1];
                end
                default: ;
            endcase
            if (wb_adr_i == A_STAT) begin
                d.sts = '0;
            end
        end
        d.sts = d.sts | ev;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.tmo <= TMO_RST;
            q.rds <= 2'h3;
            q.wrs <= 2'h3;
            q.sis <= 2'h3;
            q.rdp <= 1'b1;
            q.wrp <= 1'b1;
            q.sip <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign irq_o = |(q.sts & q.msk);
    assign tx_space_avail_n_o = !run || q.tbusy || q.tcn == TX_FULL;
    assign rx_data_avail_n_o = !run || q.rhold || q.rcn == '0;
    // Bit-bang hands the pins to software registers
    assign data_o = bb ? q.bbo : q.dout;
    assign data_oe_o = bb ? q.bbd : {8{q.doe}};
    assign power_enable_n_o = q.susp;
    assign fifo_pulldown_o = q.ctrl[C_PD] && q.susp;
    assign reset_out_n_o = q.rsto;
    assign usb_rx_ready_o = q.rss[1] && q.rcn != RX_FULL;
    assign usb_in_data_o = q.txm[q.trp];
    assign usb_in_avail_o = q.tcn != '0;
    assign usb_send_now_o = q.snow;
    assign usb_flush_o = q.flush;
    assign usb_resume_o = q.wake;
    assign usb_iso_mode_o = q.ctrl[C_ISO];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_taken;
        wr_ok && !pop;
    endsequence
    sequence s_rd_taken;
        rd_ok && !push;
    endsequence
    a_tx_store_cnt: assert property (s_wr_taken |=> q.tcn == $past(q.tcn) + 1'b1 && tx_space_avail_n_o)
        else $error("write not stored or flag low");
    a_rd_pop_cnt: assert property (s_rd_taken |=> q.rcn == $past(q.rcn) - 1'b1 && rx_data_avail_n_o)
        else $error("read did not pop");
    a_rx_empty_hi: assert property (q.rcn == '0 |-> rx_data_avail_n_o)
        else $error("receive flag low while empty");
    a_rx_flag_lo: assert property (run && !q.rhold && q.rcn != '0 |-> !rx_data_avail_n_o)
        else $error("receive flag high with data");
    a_tx_full_hi: assert property (q.tcn == TX_FULL |-> tx_space_avail_n_o)
        else $error("space flag low while full");
    a_susp_power_enable_n: assert property (usb_suspend_i |=> power_enable_n_o && (!q.ctrl[C_PD] || fifo_pulldown_o))
        else $error("suspend not shown");
    a_wake_req: assert property (si_fall && q.rss[1] && q.susp && q.ctrl[C_WAKE] |=> usb_resume_o ##1 !usb_resume_o)
        else $error("no single resume pulse");
    a_send_now: assert property (si_fall && q.rss[1] && !q.susp |=> usb_send_now_o)
        else $error("send-now not raised");
    a_rst_out: assert property (!q.rss[1] |=> !reset_out_n_o && q.tcn == '0)
        else $error("reset not passed on");
    a_bb_pins: assert property (bb |-> data_o == q.bbo && data_oe_o == q.bbd && tx_space_avail_n_o)
        else $error("bit-bang pins wrong");
endmodule

// >>> src/ufp_pkg.sv
// Shared constants of the parallel FIFO port
package ufp_pkg;
    // ****************************************
    // Buffer sizes and timing
    // ****************************************
    localparam int TX_DEPTH = 384;
    localparam int RX_DEPTH = 128;
    localparam int CLK_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS; // Cycles in one flush step
    localparam logic [7:0] TMO_RST = 8'h10; // Flush timeout after reset, ms
    localparam logic [7:0] TMO_MIN = 8'h01;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_TMO = 5'h04;
    localparam logic [4:0] A_BBO = 5'h08;
    localparam logic [4:0] A_BBD = 5'h0C;
    localparam logic [4:0] A_STAT = 5'h10;
    localparam logic [4:0] A_MASK = 5'h14;
    localparam logic [4:0] A_LVL = 5'h18;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int C_BB = 0;   // Bit-bang mode
    localparam int C_PD = 1;   // Pull lines down in suspend
    localparam int C_WAKE = 2; // Remote wakeup allowed
    localparam int C_ISO = 3;  // Isochronous transfers
    localparam int NCTL = 4;
    localparam int E_RX = 0;   // Host byte arrived
    localparam int E_OVF = 1;  // Host byte lost, buffer full
    localparam int E_FLUSH = 2;
    localparam int E_WAKE = 3;
    localparam int NEV = 4;
    localparam int L_RXC = 0;
    localparam int L_TXC = 8;
    localparam int L_PIN = 20;
endpackage

// >>> sim/ufp_mcu_model.sv
// Model of the external logic that strobes the FIFO pins
module ufp_mcu_model (
    // Clock
    input wire logic clk_i,
    // FIFO pins
    input wire logic [7:0] pin_i,
    input wire logic tx_space_avail_n_i,
    input wire logic rx_data_avail_n_i,
    output logic [7:0] data_o,
    output logic rd_n_o,
    output logic wr_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Strobe tasks
    // ****************************************
    // Idle strobes and an arbitrary idle byte
    initial begin
        data_o = 8'hFF;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    end
    // One write; f is the space flag seen once the byte is stored
    task automatic put(input logic [7:0] b, output logic f);
        int n;
        n = 0;
        while (tx_space_avail_n_i !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        data_o <= b;
        repeat (2) @(posedge clk_i);
        wr_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        // Unknown flag marks a wait that ran out
        f = (n < 300) ? tx_space_avail_n_i : 1'bx;
        wr_n_o <= 1'b1;
        @(posedge clk_i);
        // Released lines show the inverse so a stale byte never looks valid
        data_o <= ~b;
        repeat (3) @(posedge clk_i);
    endtask
    // One read; f is the data flag seen with the byte
    task automatic get(output logic [7:0] b, output logic f);
        int n;
        n = 0;
        while (rx_data_avail_n_i !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        rd_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        b = pin_i;
        f = (n < 300) ? rx_data_avail_n_i : 1'bx;
        rd_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// >>> sim/ufp_port_tb_top.sv
// Self-checking bench of the parallel FIFO port
module ufp_port_tb_top import ufp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [4:0] a; logic [31:0] e;} ufp_row_t;
    logic clk_i, rst_i, cyc, stb, wen, ack, irq, f;
    logic [4:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [7:0] pin, dut_q, dut_oe, mcu_q, b, hd, idat, tmo;
    logic rd_n, wr_n, txe_n, rxf_n, sn_n, pwr_n, pd, rin_n, rout_n;
    logic susp, hv, hrdy, pop, iav, snow, flush, resume, iso, twe;
    int error_cnt, n_tests, res_cnt, fl_cnt;
    // Reset view of the registers; idle pins read back high; last row is unmapped
    ufp_row_t rows [8] = '{'{A_CTRL, 32'h0}, '{A_TMO, {24'h0, TMO_RST}}, '{A_BBO, 32'h0},
        '{A_BBD, 32'h0}, '{A_STAT, 32'h0}, '{A_MASK, 32'h0}, '{A_LVL, 32'h0FF0_0000}, '{5'h1C, 32'h0}};
    // Wire level from the port's enable; the model drives every bit the port releases
    assign pin = (dut_oe & dut_q) | (~dut_oe & mcu_q);
    ufp_port #(.TXD(4), .RXD(4), .MSC(10)) u_ufp_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .data_i(pin), .data_o(dut_q), .data_oe_o(dut_oe), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .tx_space_avail_n_o(txe_n), .rx_data_avail_n_o(rxf_n), .send_now_wake_n_i(sn_n),
        .power_enable_n_o(pwr_n), .fifo_pulldown_o(pd), .reset_in_n_i(rin_n), .reset_out_n_o(rout_n),
        .usb_suspend_i(susp), .usb_rx_valid_i(hv), .usb_rx_data_i(hd), .usb_rx_ready_o(hrdy),
        .usb_in_pop_i(pop), .usb_in_data_o(idat), .usb_in_avail_o(iav), .usb_send_now_o(snow),
        .usb_flush_o(flush), .usb_resume_o(resume), .usb_iso_mode_o(iso), .usb_tmo_we_i(twe),
        .usb_tmo_i(tmo));
    ufp_mcu_model u_ufp_mcu_model (.clk_i(clk_i), .pin_i(pin), .tx_space_avail_n_i(txe_n),
        .rx_data_avail_n_i(rxf_n), .data_o(mcu_q), .rd_n_o(rd_n), .wr_n_o(wr_n));
    // ****************************************
    // Clock, monitors and tasks
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Pulses are counted so that no single cycle has to be hit
    always @(posedge clk_i) begin
        if (resume === 1'b1) res_cnt <= res_cnt + 1;
        if (flush === 1'b1) fl_cnt <= fl_cnt + 1;
    end
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        // A missing answer counts against the run
        if (ack !== 1'b1) error_cnt++;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic hsend(input logic [7:0] v);
        hv <= 1'b1;
        hd <= v;
        @(posedge clk_i);
        hv <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic hpop(input logic [7:0] e);
        chk32({24'h0, idat}, {24'h0, e});
        pop <= 1'b1;
        @(posedge clk_i);
        pop <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic strobe();
        sn_n <= 1'b0;
        repeat (5) @(posedge clk_i);
        sn_n <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic set_tmo(input logic [7:0] v);
        twe <= 1'b1;
        tmo <= v;
        @(posedge clk_i);
        twe <= 1'b0;
        @(posedge clk_i);
    endtask
    // Watchdog well beyond the few hundred cycles of the run
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {cyc, stb, wen, adr, wdat, hv, hd, pop, twe, tmo, susp} = '0;
        {rst_i, sn_n, rin_n} = 3'b111;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk1(rout_n, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, rows[i].a, 32'h0, q);
            chk32(q, rows[i].e);
        end
        // Overfill the receive side, then drain it through the pins
        wb(1'b1, A_MASK, 32'h1, q);
        for (int i = 0; i < 5; i++) hsend(8'(8'h30 + i));
        chk1(rxf_n, 1'b0);
        chk1(hrdy, 1'b0);
        chk1(irq, 1'b1);
        wb(1'b0, A_STAT, 32'h0, q);
        chk32(q, 32'h3);
        chk1(irq, 1'b0);
        for (int i = 0; i < 4; i++) begin
            u_ufp_mcu_model.get(b, f);
            chk32({24'h0, b}, {24'h0, 8'(8'h30 + i)});
            chk1(f, 1'b1);
        end
        repeat (6) @(posedge clk_i);
        chk1(rxf_n, 1'b1);
        // Short timeout, one byte, flush timing
        set_tmo(8'h02);
        wb(1'b0, A_TMO, 32'h0, q);
        chk32(q, 32'h2);
        u_ufp_mcu_model.put(8'hA5, f);
        chk1(f, 1'b1);
        repeat (10) @(posedge clk_i);
        chk32(fl_cnt, 32'h0);
        repeat (10) @(posedge clk_i);
        chk32(fl_cnt, 32'h1);
        chk1(iav, 1'b1);
        hpop(8'hA5);
        for (int i = 0; i < 4; i++) begin
            u_ufp_mcu_model.put(8'(8'hC0 + i), f);
            chk1(f, 1'b1);
        end
        repeat (8) @(posedge clk_i);
        chk1(txe_n, 1'b1);
        for (int i = 0; i < 4; i++) hpop(8'(8'hC0 + i));
        repeat (8) @(posedge clk_i);
        chk1(txe_n, 1'b0);
        chk1(iav, 1'b0);
        set_tmo(8'h00);
        wb(1'b0, A_TMO, 32'h0, q);
        chk32(q, 32'h1);
        // Suspend, pulldown option, wakeup refused then allowed
        susp <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk1(pwr_n, 1'b1);
        chk1(pd, 1'b0);
        strobe();
        chk32(res_cnt, 32'h0);
        wb(1'b1, A_CTRL, 32'h6, q);
        chk1(pd, 1'b1);
        strobe();
        chk32(res_cnt, 32'h1);
        susp <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk1(pwr_n, 1'b0);
        strobe();
        chk1(snow, 1'b1);
        wb(1'b1, A_CTRL, 32'h8, q);
        chk1(iso, 1'b1);
        // Bit-bang drives the lines and holds the space flag high, then external reset reaches the reset output
        wb(1'b1, A_CTRL, 32'h1, q);
        wb(1'b1, A_BBO, 32'h5A, q);
        wb(1'b1, A_BBD, 32'hFF, q);
        repeat (3) @(posedge clk_i);
        chk32({24'h0, dut_q}, 32'h5A);
        chk32({24'h0, dut_oe}, 32'hFF);
        chk1(txe_n, 1'b1);
        wb(1'b1, A_CTRL, 32'h0, q);
        rin_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk1(rout_n, 1'b0);
        rin_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk1(rout_n, 1'b1);
        stop_test();
    end
endmodule
